// [common/srbh_consts.svh]
// Purpose: Offsets, field positions, reset values and timing figures for srbh
// Assumes: 32-bit APB, byte addresses
// Notes: Included by the package and the design files
`ifndef SRBH_CONSTS_SVH
`define SRBH_CONSTS_SVH
`define SRBH_OFF_SDCTRL 8'h00
`define SRBH_OFF_PERIOD 8'h04
`define SRBH_OFF_SPACE 8'h08
`define SRBH_OFF_GCTRL 8'h0C
`define SRBH_OFF_STATUS 8'h10
`define SRBH_REFEN_BIT 0
`define SRBH_BLOCK_BIT 0
`define SRBH_REFEN_RST 1'h1
`define SRBH_BLOCK_RST 1'h0
`define SRBH_PERIOD_W 12
`define SRBH_PERIOD_RST 12'h5DC
`define SRBH_N_CE 4
`define SRBH_MEMORY_TYPE_FIELD_W 2
`define SRBH_SPACE_RST 8'h00
`define SRBH_MEMORY_TYPE_FIELD_SDRAM 2'h3
`define SRBH_BACKLOG_W 4
`define SRBH_URGENT_LVL 4'h4
`define SRBH_ST_GRANT_BIT 0
`define SRBH_ST_URGENT_BIT 1
`define SRBH_ST_INITPRE_BIT 2
`define SRBH_ST_BACKLOG_LSB 4
`define SRBH_CLK_MHZ 50
`define SRBH_TRP_NS 20
`define SRBH_TRFC_NS 70
`endif

// [common/srbh_pkg.sv]
// Purpose: Types shared by the srbh design files
// Assumes: srbh_consts.svh sizes the pin group
// Notes: Constants live in the header as macros
`include "srbh_consts.svh"
package srbh_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_PRE, ST_PRE_W, ST_REF, ST_REF_W, ST_HPRE, ST_HPRE_W, ST_HOFF, ST_HOLD
  } srbh_state_t;
  typedef struct packed {
    logic [`SRBH_N_CE-1:0] cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic a10;
  } srbh_sd_pins_t;
endpackage

// [dv/sdram_refresh_and_bus_hold_tb.sv]
// Purpose: Self-checking bench for srbh_top
// Assumes: APB with zero wait states; far side modelled by srbh_far_model
// Notes: Short refresh intervals keep the run brief
`timescale 1ns/100ps
`default_nettype none
`include "srbh_consts.svh"
module sdram_refresh_and_bus_hold_tb;
  import srbh_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, refresh_stall, page_inval, sd_oe_n, clock_output_pin;
  logic acc_pending = 1'b0, acc_inflight = 1'b0, rows_open = 1'b0, want_bus = 1'b0;
  logic ext_bus_req_n, ext_bus_grant_n;
  srbh_sd_pins_t sd_pins;
  logic [15:0] n_pre, n_ref;
  logic [3:0] last_cs_n;
  logic [7:0] n_bad;
  int n_mismatch = 0, samples_checked = 0, n_inval = 0;
  always #10 pclk = ~pclk;
  always @(posedge pclk) if (page_inval === 1'b1) n_inval <= n_inval + 1;
  srbh_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .acc_pending(acc_pending), .acc_inflight(acc_inflight),
    .rows_open(rows_open), .refresh_stall(refresh_stall), .page_inval(page_inval),
    .sd_pins(sd_pins), .sd_oe_n(sd_oe_n), .clock_output_pin(clock_output_pin),
    .ext_bus_req_n(ext_bus_req_n), .ext_bus_grant_n(ext_bus_grant_n));
  srbh_far_model far (.pclk(pclk), .sd_pins(sd_pins), .sd_oe_n(sd_oe_n),
    .ext_bus_grant_n(ext_bus_grant_n), .want_bus(want_bus), .ext_bus_req_n(ext_bus_req_n),
    .n_pre(n_pre), .n_ref(n_ref), .last_cs_n(last_cs_n), .n_bad(n_bad));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    rd(`SRBH_OFF_SDCTRL, q);
    chk(q, 32'h1);
    rd(`SRBH_OFF_PERIOD, q);
    chk(q, {20'h0, `SRBH_PERIOD_RST});
    rd(`SRBH_OFF_SPACE, q);
    chk(q, 32'h0);
    rd(`SRBH_OFF_GCTRL, q);
    chk(q, 32'h0);
    apb(1'b1, 8'h14, 32'hFFFFFFFF, q, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h14, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
  endtask
  task automatic t_refresh();
    int i, s, v;
    wr(`SRBH_OFF_PERIOD, 32'h3);
    wr(`SRBH_OFF_SPACE, 32'h0C);
    s = n_ref;
    v = n_inval;
    for (i = 0; i < 300 && n_ref == s; i++) @(posedge pclk);
    repeat (6) @(posedge pclk);
    chk({28'h0, last_cs_n}, 32'hD);
    chk(32'(n_ref > s), 32'h1);
    chk({24'h0, n_bad}, 32'h0);
    chk(32'(n_inval - v >= 2), 32'h1);
  endtask
  task automatic t_off();
    logic [31:0] q;
    int s;
    wr(`SRBH_OFF_SDCTRL, 32'h0);
    repeat (20) @(posedge pclk);
    s = n_ref;
    repeat (200) @(posedge pclk);
    chk(32'(n_ref), 32'(s));
    rd(`SRBH_OFF_STATUS, q);
    chk(q & 32'hF0, 32'h0);
    wr(`SRBH_OFF_SDCTRL, 32'h1);
  endtask
  task automatic t_urgent();
    int i, s;
    wr(`SRBH_OFF_PERIOD, 32'h14);
    acc_pending <= 1'b1;
    repeat (20) @(posedge pclk);
    s = n_ref;
    for (i = 0; i < 600 && refresh_stall !== 1'b1; i++) @(posedge pclk);
    chk(32'(n_ref), 32'(s));
    chk({31'h0, refresh_stall}, 32'h1);
    for (i = 0; i < 50 && n_ref == s; i++) @(posedge pclk);
    chk(32'(n_ref), 32'(s + 1));
    for (i = 0; i < 50 && refresh_stall !== 1'b0; i++) @(posedge pclk);
    chk({31'h0, refresh_stall}, 32'h0);
    repeat (12) @(posedge pclk);
    chk(32'(n_ref), 32'(s + 1));
    acc_pending <= 1'b0;
  endtask
  task automatic t_hold();
    logic c;
    int i, s;
    wr(`SRBH_OFF_SDCTRL, 32'h0);
    rows_open <= 1'b1;
    acc_inflight <= 1'b1;
    want_bus <= 1'b1;
    for (i = 0; i < 20 && ext_bus_req_n !== 1'b0; i++) @(posedge pclk);
    repeat (2) @(posedge pclk);
    chk({31'h0, ext_bus_grant_n}, 32'h1);
    repeat (20) @(posedge pclk);
    chk({31'h0, ext_bus_grant_n}, 32'h1);
    s = n_pre;
    acc_inflight <= 1'b0;
    for (i = 0; i < 40 && ext_bus_grant_n !== 1'b0; i++) @(posedge pclk);
    chk({31'h0, ext_bus_grant_n}, 32'h0);
    chk({31'h0, sd_oe_n}, 32'h1);
    chk(32'(n_pre), 32'(s + 1));
    c = clock_output_pin;
    @(posedge pclk);
    chk({31'h0, clock_output_pin}, {31'h0, ~c});
    want_bus <= 1'b0;
    for (i = 0; i < 20 && ext_bus_grant_n !== 1'b1; i++) @(posedge pclk);
    chk({sd_oe_n, n_bad, ext_bus_grant_n}, 10'h001);
    rows_open <= 1'b0;
    wr(`SRBH_OFF_GCTRL, 32'h1);
    want_bus <= 1'b1;
    repeat (50) @(posedge pclk);
    chk({sd_oe_n, ext_bus_grant_n}, 2'h1);
    want_bus <= 1'b0;
    repeat (5) @(posedge pclk);
    wr(`SRBH_OFF_GCTRL, 32'h0);
  endtask
  task automatic t_reset_hold();
    logic [31:0] q;
    want_bus <= 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({31'h0, ext_bus_grant_n}, 32'h1);
    @(posedge pclk);
    chk({31'h0, ext_bus_grant_n}, 32'h0);
    repeat (5) @(posedge pclk);
    rd(`SRBH_OFF_STATUS, q);
    chk(q & 32'h4, 32'h4);
    want_bus <= 1'b0;
    repeat (30) @(posedge pclk);
    rd(`SRBH_OFF_STATUS, q);
    chk(q & 32'h5, 32'h0);
    chk({24'h0, n_bad}, 32'h0);
  endtask
  task automatic finish_test();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    t_regs();
    t_refresh();
    t_off();
    t_urgent();
    t_hold();
    t_reset_hold();
    finish_test();
  end
endmodule // sdram_refresh_and_bus_hold_tb
`default_nettype wire

// [dv/srbh_far_model.sv]
// Purpose: SDRAM devices and an outside bus master facing srbh_top
// Assumes: Commands are decoded on pclk while the block drives the pins
// Notes: Counts commands; counts misordered refreshes and bus clashes
`timescale 1ns/100ps
`default_nettype none
module srbh_far_model (
  // Clock
  input wire logic pclk,
  // Pins from the block
  input wire srbh_pkg::srbh_sd_pins_t sd_pins,
  input wire logic sd_oe_n,
  input wire logic ext_bus_grant_n,
  // Master control and tallies
  input wire logic want_bus,
  output logic ext_bus_req_n,
  output logic [15:0] n_pre,
  output logic [15:0] n_ref,
  output logic [3:0] last_cs_n,
  output logic [7:0] n_bad
);
  import srbh_pkg::*;
  logic req_n_q = 1'b1;
  logic drives = 1'b0;
  logic precharged = 1'b0;
  logic [15:0] pre_q = '0;
  logic [15:0] ref_q = '0;
  logic [3:0] cs_q = 4'hF;
  logic [7:0] bad_q = '0;
  logic act;
  assign ext_bus_req_n = req_n_q;
  assign n_pre = pre_q;
  assign n_ref = ref_q;
  assign last_cs_n = cs_q;
  assign n_bad = bad_q;
  assign act = !sd_oe_n && (sd_pins.cs_n != 4'hF) && !sd_pins.ras_n;
  always @(posedge pclk) begin
    // Stop driving before the request is raised again
    drives <= want_bus && (ext_bus_grant_n === 1'b0);
    req_n_q <= !(want_bus || drives);
    if (drives && sd_oe_n !== 1'b1) begin
      bad_q <= bad_q + 8'h01;
    end
    if (act && sd_pins.cas_n && !sd_pins.we_n && sd_pins.a10) begin
      pre_q <= pre_q + 16'h0001;
      precharged <= 1'b1;
      cs_q <= sd_pins.cs_n;
    end
    if (act && !sd_pins.cas_n && sd_pins.we_n) begin
      ref_q <= ref_q + 16'h0001;
      precharged <= 1'b0;
      cs_q <= sd_pins.cs_n;
      if (!precharged) begin
        bad_q <= bad_q + 8'h01;
      end
    end
  end
endmodule // srbh_far_model
`default_nettype wire

// [hw/srbh_sync.sv]
// Purpose: Multi-stage level synchronizer
// Assumes: Input is a slow level from outside the clock domain
// Notes: Only the last stage may be read by other logic
`timescale 1ns/100ps
`default_nettype none
module srbh_sync #(
  parameter int STAGES = 2,
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Level in and out
  input wire logic din,
  output logic dout
);
  logic [STAGES-1:0] stage_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_r <= {STAGES{RST_VAL}};
    end else begin
      stage_r <= {stage_r[STAGES-2:0], din};
    end
  end

  assign dout = stage_r[STAGES-1];
endmodule // srbh_sync
`default_nettype wire

// [hw/srbh_top.sv]
// Purpose: SDRAM refresh scheduler and external bus hold arbiter
// Assumes: Memory clock is pclk divided by two and leaves on clock_output_pin
// Notes: Access datapath reports pending and in-flight work; this block owns the pins
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "srbh_consts.svh"
module srbh_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Access datapath status
  input wire logic acc_pending,
  input wire logic acc_inflight,
  input wire logic rows_open,
  output logic refresh_stall,
  output logic page_inval,
  // SDRAM command pins
  output srbh_pkg::srbh_sd_pins_t sd_pins,
  output logic sd_oe_n,
  output logic clock_output_pin,
  // Bus hold handshake
  input wire logic ext_bus_req_n,
  output logic ext_bus_grant_n
);
  import srbh_pkg::*;

  localparam int TRP_CYC = (`SRBH_TRP_NS * `SRBH_CLK_MHZ + 999) / 1000;
  localparam int TRFC_CYC = (`SRBH_TRFC_NS * `SRBH_CLK_MHZ + 999) / 1000;
  localparam int TRP_MAX = TRP_CYC + 2;
  localparam int TRFC_MAX = TRFC_CYC + 2;
  localparam logic [3:0] TRP_W = 4'(TRP_CYC - 1);
  localparam logic [3:0] TRFC_W = 4'(TRFC_CYC - 1);
  localparam int BW = `SRBH_BACKLOG_W;

  function automatic logic [`SRBH_N_CE-1:0] sdram_mask(
    input logic [`SRBH_N_CE*`SRBH_MEMORY_TYPE_FIELD_W-1:0] types
  );
    logic [`SRBH_N_CE-1:0] m;
    m = '0;
    for (int i = 0; i < `SRBH_N_CE; i++) begin
      m[i] = (types[i*`SRBH_MEMORY_TYPE_FIELD_W +: `SRBH_MEMORY_TYPE_FIELD_W] == `SRBH_MEMORY_TYPE_FIELD_SDRAM);
    end
    return m;
  endfunction

  srbh_state_t state_r, state_nxt;
  logic refen_r;
  logic block_r;
  logic [`SRBH_PERIOD_W-1:0] period_r;
  logic [`SRBH_N_CE*`SRBH_MEMORY_TYPE_FIELD_W-1:0] space_r;
  logic [31:0] prdata_r;
  logic clock_output_pin_r;
  logic prime_r;
  logic [`SRBH_PERIOD_W-1:0] tick_cnt_r;
  logic [BW-1:0] backlog_r;
  logic urgent_r;
  logic ref_run_r;
  logic init_pre_r;
  logic [3:0] wait_r;
  srbh_sd_pins_t pins_r;
  logic oe_n_r;
  logic grant_n_r;
  logic page_inval_r;
  logic req_n_sync;
  logic hold_want;
  logic interval_done;
  logic ref_done;
  logic [`SRBH_N_CE-1:0] sd_mask;
  logic wr_en;
  logic addr_ok;

  // APB: zero wait states, read data latched in the setup cycle
  assign wr_en = psel & penable & pwrite;
  assign addr_ok = (paddr == `SRBH_OFF_SDCTRL) || (paddr == `SRBH_OFF_PERIOD) ||
                   (paddr == `SRBH_OFF_SPACE) || (paddr == `SRBH_OFF_GCTRL) ||
                   (paddr == `SRBH_OFF_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refen_r <= `SRBH_REFEN_RST;
      period_r <= `SRBH_PERIOD_RST;
      space_r <= `SRBH_SPACE_RST;
      block_r <= `SRBH_BLOCK_RST;
    end else if (wr_en) begin
      case (paddr)
        `SRBH_OFF_SDCTRL: refen_r <= pwdata[`SRBH_REFEN_BIT];
        `SRBH_OFF_PERIOD: period_r <= pwdata[`SRBH_PERIOD_W-1:0];
        `SRBH_OFF_SPACE: space_r <= pwdata[`SRBH_N_CE*`SRBH_MEMORY_TYPE_FIELD_W-1:0];
        `SRBH_OFF_GCTRL: block_r <= pwdata[`SRBH_BLOCK_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= 32'h0000_0000;
      case (paddr)
        `SRBH_OFF_SDCTRL: prdata_r[`SRBH_REFEN_BIT] <= refen_r;
        `SRBH_OFF_PERIOD: prdata_r[`SRBH_PERIOD_W-1:0] <= period_r;
        `SRBH_OFF_SPACE: prdata_r[`SRBH_N_CE*`SRBH_MEMORY_TYPE_FIELD_W-1:0] <= space_r;
        `SRBH_OFF_GCTRL: prdata_r[`SRBH_BLOCK_BIT] <= block_r;
        `SRBH_OFF_STATUS: begin
          prdata_r[`SRBH_ST_GRANT_BIT] <= ~grant_n_r;
          prdata_r[`SRBH_ST_URGENT_BIT] <= urgent_r;
          prdata_r[`SRBH_ST_INITPRE_BIT] <= init_pre_r;
          prdata_r[`SRBH_ST_BACKLOG_LSB +: BW] <= backlog_r;
        end
        default: ;
      endcase
    end
  end

  // Bus request crossing; the first stage stays private to the synchronizer
  srbh_sync #(.STAGES(2), .RST_VAL(1'b1)) u_req_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(ext_bus_req_n),
    .dout(req_n_sync)
  );

  assign hold_want = ~req_n_sync & ~block_r;

  // Half-rate memory clock, never stopped; prime_r waits out the request sync after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_output_pin_r <= 1'b0;
      prime_r <= 1'b0;
    end else begin
      clock_output_pin_r <= ~clock_output_pin_r;
      prime_r <= prime_r | clock_output_pin_r;
    end
  end
  assign clock_output_pin = clock_output_pin_r;

  // Interval timer advances once per memory-clock cycle
  assign interval_done = clock_output_pin_r && (tick_cnt_r >= period_r);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= '0;
    end else if (interval_done) begin
      tick_cnt_r <= '0;
    end else if (clock_output_pin_r) begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  // Backlog of intervals with no refresh; a done refresh and a new interval cancel out
  assign ref_done = (state_r == ST_REF_W) && (wait_r == 4'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      backlog_r <= '0;
    end else if (!refen_r) begin
      backlog_r <= '0;
    end else if (interval_done && !ref_done && backlog_r != {BW{1'b1}}) begin
      backlog_r <= backlog_r + 1'b1;
    end else if (ref_done && !interval_done && backlog_r != '0) begin
      backlog_r <= backlog_r - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      urgent_r <= 1'b0;
    end else begin
      urgent_r <= refen_r && (backlog_r >= `SRBH_URGENT_LVL);
    end
  end

  // Stall the datapath only while urgent, so trickle refresh never costs bandwidth
  assign refresh_stall = urgent_r;
  assign sd_mask = sdram_mask(space_r);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (hold_want && !acc_inflight) begin
          state_nxt = rows_open ? ST_HPRE : ST_HOFF;
        end else if (init_pre_r && !hold_want && prime_r) begin
          state_nxt = ST_PRE;
        end else if (refen_r && backlog_r != '0 && sd_mask != '0 && !acc_inflight &&
                     ((urgent_r && backlog_r >= `SRBH_URGENT_LVL) || !acc_pending)) begin
          state_nxt = ST_PRE;
        end
      end
      ST_PRE: state_nxt = ST_PRE_W;
      ST_PRE_W: begin
        if (wait_r == 4'h0) begin
          state_nxt = ref_run_r ? ST_REF : ST_IDLE;
        end
      end
      ST_REF: state_nxt = ST_REF_W;
      ST_REF_W: begin
        if (wait_r == 4'h0) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_HPRE: state_nxt = ST_HPRE_W;
      ST_HPRE_W: begin
        if (wait_r == 4'h0) begin
          state_nxt = ST_HOFF;
        end
      end
      ST_HOFF: state_nxt = hold_want ? ST_HOLD : ST_IDLE;
      ST_HOLD: begin
        if (!hold_want) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Marks whether the current precharge belongs to a refresh or to the reset sweep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_run_r <= 1'b0;
      init_pre_r <= 1'b1;
    end else if (state_r == ST_IDLE && state_nxt == ST_PRE) begin
      ref_run_r <= ~init_pre_r;
      init_pre_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r <= 4'h0;
    end else if (state_r == ST_PRE || state_r == ST_HPRE) begin
      wait_r <= TRP_W;
    end else if (state_r == ST_REF) begin
      wait_r <= TRFC_W;
    end else if (wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
    end
  end

  // Command pins are registered; all SDRAM spaces see the command together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_r <= '{cs_n: '1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, a10: 1'b0};
    end else begin
      pins_r <= '{cs_n: '1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, a10: 1'b0};
      if (state_r == ST_PRE || state_r == ST_HPRE) begin
        pins_r <= '{cs_n: ~sd_mask, ras_n: 1'b0, cas_n: 1'b1, we_n: 1'b0, a10: 1'b1};
      end else if (state_r == ST_REF) begin
        pins_r <= '{cs_n: ~sd_mask, ras_n: 1'b0, cas_n: 1'b0, we_n: 1'b1, a10: 1'b0};
      end
    end
  end
  assign sd_pins = pins_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_inval_r <= 1'b0;
    end else begin
      page_inval_r <= (state_r == ST_PRE) || (state_r == ST_HPRE) || ref_done;
    end
  end
  assign page_inval = page_inval_r;

  // Outputs go off one cycle before the grant can show
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_n_r <= 1'b0;
      grant_n_r <= 1'b1;
    end else begin
      oe_n_r <= (state_nxt == ST_HOFF) || (state_nxt == ST_HOLD);
      grant_n_r <= ~((state_nxt == ST_HOLD) && oe_n_r);
    end
  end
  assign sd_oe_n = oe_n_r;
  assign ext_bus_grant_n = grant_n_r;

  a_ref_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_IDLE && state_nxt == ST_PRE && !init_pre_r) |-> refen_r)
    else $error("refresh started while refresh disabled");

  a_pre_then_ref: assert property (@(posedge pclk) disable iff (!presetn)
    (!pins_r.ras_n && !pins_r.cas_n) |-> $past(!pins_r.ras_n && pins_r.cas_n, TRP_CYC + 1))
    else $error("refresh not preceded by precharge-all");

  a_ref_follows_pre: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_PRE && ref_run_r) |-> ##[1:TRP_MAX] (state_r == ST_REF))
    else $error("refresh did not follow its precharge");

  a_cmd_sdram_only: assert property (@(posedge pclk) disable iff (!presetn)
    !pins_r.ras_n |-> (pins_r.cs_n == ~$past(sd_mask)))
    else $error("command sent to a non-SDRAM space");

  a_page_inval_ref: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_REF) |-> ##[1:TRFC_MAX] page_inval_r)
    else $error("page state not invalidated after refresh");

  a_trickle_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_IDLE && state_nxt == ST_PRE && !urgent_r && !init_pre_r) |-> !acc_pending)
    else $error("trickle refresh began with access pending");

  a_urgent_stall: assert property (@(posedge pclk) disable iff (!presetn)
    (refen_r && $past(backlog_r) >= `SRBH_URGENT_LVL) |-> refresh_stall)
    else $error("urgent backlog without raised priority");

  a_grant_after_off: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(grant_n_r) |-> (oe_n_r && $past(oe_n_r)))
    else $error("grant given before outputs were off");

  a_off_while_held: assert property (@(posedge pclk) disable iff (!presetn)
    !grant_n_r |-> (oe_n_r && clock_output_pin != $past(clock_output_pin)))
    else $error("outputs driven or clock stopped while granted");

  a_block_no_grant: assert property (@(posedge pclk) disable iff (!presetn)
    (block_r && grant_n_r) |=> grant_n_r)
    else $error("bus granted while requests are blocked");

  a_grant_release: assert property (@(posedge pclk) disable iff (!presetn)
    (!grant_n_r && req_n_sync) |=> (grant_n_r && !oe_n_r))
    else $error("grant kept after request withdrawn");

  a_init_pre_defer: assert property (@(posedge pclk) disable iff (!presetn)
    (init_pre_r && hold_want) |=> (state_r != ST_PRE))
    else $error("reset precharge issued during bus request");
endmodule // srbh_top
`default_nettype wire
